// File: inc/pps_pkg.sv
package pps_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;

	localparam logic [ADDR_W-1:0] ADDR_TX_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] ADDR_CFG     = 4'h1;
	localparam logic [ADDR_W-1:0] ADDR_PHY_ST  = 4'h2;
	localparam logic [ADDR_W-1:0] ADDR_RX_ST   = 4'h3;
	localparam logic [ADDR_W-1:0] ADDR_MGMT    = 4'h4;

	localparam int TX_CTRL_LOOP_BIT   = 1;
	localparam int CFG_ATTACH_BIT     = 8;
	localparam int CFG_FULL_STEP_BIT  = 10;
	localparam int CFG_MEDIA_SEL_BIT  = 15;
	localparam int PHY_ST_LINK_BIT    = 14;
	localparam int RX_ST_DONE_BIT     = 0;
	localparam int RX_ST_BAD_CRC_BIT  = 13;
	localparam int MGMT_DOUT_BIT      = 0;
	localparam int MGMT_MCLK_BIT      = 1;
	localparam int MGMT_DIN_BIT       = 2;

	localparam logic [DATA_W-1:0] TX_CTRL_RST = 16'h0000;
	localparam logic [DATA_W-1:0] CFG_RST     = 16'h0000;
	localparam logic [DATA_W-1:0] RX_ST_RST   = 16'h0000;
	localparam logic [DATA_W-1:0] MGMT_RST    = 16'h0000;

	// Nibble clock rate versus core clock; the core needs at least four samples per nibble
	localparam int SYS_CLK_HZ         = 100_000_000;
	localparam int TX_NIBBLE_CLK_HZ   = 25_000_000;
	localparam int SYS_PER_NIBBLE_CYC = SYS_CLK_HZ / TX_NIBBLE_CLK_HZ;

	typedef enum logic [2:0] {
		RX_IDLE = 3'b001,
		RX_LO   = 3'b010,
		RX_HI   = 3'b100
	} pps_rx_state_e;

	typedef struct packed {
		logic       first;
		logic [7:0] data;
	} pps_rx_beat_s;

	typedef struct packed {
		logic       fast_crs;
		logic       fast_col;
		logic       rx_dv;
		logic       rx_er;
		logic [3:0] rxd;
		logic       endec_crs;
		logic       endec_col;
		logic       link_n;
		logic       mgmt_din;
	} pps_pins_s;
endpackage

// File: design/pps_sync.sv
`timescale 1ns/1ps
module pps_sync #(
	parameter int W = 1
) (
	input  wire logic         sys_clk_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta_r;

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			meta_r <= '0;
			q_o    <= '0;
		end else begin
			meta_r <= d_i;
			q_o    <= meta_r;
		end
	end
endmodule

// File: design/pps_clk_edge.sv
`timescale 1ns/1ps
module pps_clk_edge (
	input  wire logic sys_clk_i,
	input  wire logic rst_i,
	input  wire logic clk_pin_i,
	output logic      rise_o
);
	logic meta_r;
	logic sync_r;
	logic prev_r;

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			// Idle level of a pulled-up clock pin, so leaving reset shows no false rise
			meta_r <= 1'b1;
			sync_r <= 1'b1;
			prev_r <= 1'b1;
		end else begin
			meta_r <= clk_pin_i;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	// Same sampling depth as the data synchroniser, so data and edge stay aligned
	assign rise_o = sync_r & ~prev_r;
endmodule

// File: design/pps_top.sv
// Implementation choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module pps_top
	import pps_pkg::*;
(
	input  wire logic              sys_clk_i,
	input  wire logic              rst_i,
	input  wire logic [ADDR_W-1:0] reg_addr_i,
	input  wire logic [DATA_W-1:0] reg_wdata_i,
	input  wire logic              reg_wr_i,
	input  wire logic              reg_rd_i,
	output logic      [DATA_W-1:0] reg_rdata_o,
	input  wire logic              tx_valid_i,
	input  wire logic [3:0]        tx_nibble_i,
	output logic                   tx_ready_o,
	output pps_rx_beat_s           rx_beat_o,
	output logic                   rx_beat_valid_o,
	output logic                   rx_discard_o,
	output logic                   carrier_o,
	output logic                   collision_o,
	output logic                   loopback_out_o,
	output logic                   full_step_out_n_o,
	output logic                   media_port_select_out_o,
	output logic                   attachment_select_out_o,
	input  wire logic              link_status_in_n_i,
	output logic                   fast_tx_envelope_o,
	output logic      [3:0]        mii_txd_o,
	input  wire logic              phy_tx_nibble_clock_i,
	input  wire logic              fast_carrier_sense_i,
	input  wire logic              mii_rx_dv_i,
	input  wire logic              fast_collision_in_i,
	input  wire logic              phy_rx_nibble_clock_i,
	input  wire logic [3:0]        mii_rxd_i,
	input  wire logic              mii_rx_er_i,
	input  wire logic              mgmt_data_in_i,
	output logic                   mgmt_data_out_o,
	output logic                   mgmt_clock_o,
	output logic                   endec_tx_enable_o,
	input  wire logic              endec_carrier_i,
	input  wire logic              endec_collision_i
);
	logic [DATA_W-1:0] tx_ctrl_r;
	logic [DATA_W-1:0] cfg_r;
	logic [DATA_W-1:0] mgmt_r;
	logic [DATA_W-1:0] rx_stat_r;
	logic [DATA_W-1:0] rx_stat_nxt;
	logic [DATA_W-1:0] phy_stat;
	logic [DATA_W-1:0] mgmt_rd;
	pps_pins_s         pins_raw;
	pps_pins_s         pins_s;
	logic              tx_rise;
	logic              rx_rise;
	logic              mii_sel;
	pps_rx_state_e     rx_st_r;
	logic [3:0]        lo_nib_r;
	logic              err_r;
	logic              first_r;
	logic              frame_end;
	logic              frame_bad;

	assign mii_sel = cfg_r[CFG_MEDIA_SEL_BIT];

	// Every pin from the PHY or encoder is outside the core clock domain
	assign pins_raw = '{fast_crs: fast_carrier_sense_i, fast_col: fast_collision_in_i,
		rx_dv: mii_rx_dv_i, rx_er: mii_rx_er_i, rxd: mii_rxd_i,
		endec_crs: endec_carrier_i, endec_col: endec_collision_i,
		link_n: link_status_in_n_i, mgmt_din: mgmt_data_in_i};

	pps_sync #(
		.W($bits(pps_pins_s))
	) u_pin_sync (
		.sys_clk_i(sys_clk_i),
		.rst_i    (rst_i),
		.d_i      (pins_raw),
		.q_o      (pins_s)
	);

	pps_clk_edge u_tx_edge (
		.sys_clk_i(sys_clk_i),
		.rst_i    (rst_i),
		.clk_pin_i(phy_tx_nibble_clock_i),
		.rise_o   (tx_rise)
	);

	pps_clk_edge u_rx_edge (
		.sys_clk_i(sys_clk_i),
		.rst_i    (rst_i),
		.clk_pin_i(phy_rx_nibble_clock_i),
		.rise_o   (rx_rise)
	);

	// Software-written control registers
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			tx_ctrl_r <= TX_CTRL_RST;
			cfg_r  <= CFG_RST;
			mgmt_r <= MGMT_RST;
		end else if (reg_wr_i) begin
			case (reg_addr_i)
				ADDR_TX_CTRL: tx_ctrl_r <= reg_wdata_i;
				ADDR_CFG:  cfg_r  <= reg_wdata_i;
				ADDR_MGMT: mgmt_r <= reg_wdata_i;
				default:   ;
			endcase
		end
	end

	// Receive status: write one to clear, a new event in the same cycle wins
	always_comb begin
		rx_stat_nxt = rx_stat_r;
		if (reg_wr_i && reg_addr_i == ADDR_RX_ST) begin
			rx_stat_nxt = rx_stat_r & ~reg_wdata_i;
		end
		if (frame_end) begin
			rx_stat_nxt[RX_ST_DONE_BIT] = 1'b1;
			rx_stat_nxt[RX_ST_BAD_CRC_BIT] = rx_stat_nxt[RX_ST_BAD_CRC_BIT] | frame_bad;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			rx_stat_r <= RX_ST_RST;
		end else begin
			rx_stat_r <= rx_stat_nxt;
		end
	end

	always_comb begin
		phy_stat = '0;
		phy_stat[PHY_ST_LINK_BIT] = ~pins_s.link_n;
		mgmt_rd = '0;
		mgmt_rd[MGMT_DOUT_BIT] = mgmt_r[MGMT_DOUT_BIT];
		mgmt_rd[MGMT_MCLK_BIT] = mgmt_r[MGMT_MCLK_BIT];
		mgmt_rd[MGMT_DIN_BIT] = pins_s.mgmt_din;
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			reg_rdata_o <= '0;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
				ADDR_TX_CTRL: reg_rdata_o <= tx_ctrl_r;
				ADDR_CFG:    reg_rdata_o <= cfg_r;
				ADDR_PHY_ST: reg_rdata_o <= phy_stat;
				ADDR_RX_ST:  reg_rdata_o <= rx_stat_r;
				ADDR_MGMT:   reg_rdata_o <= mgmt_rd;
				default:     reg_rdata_o <= '0;
			endcase
		end else begin
			reg_rdata_o <= '0;
		end
	end

	// Configuration pins, held steady whatever the port selection
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			loopback_out_o          <= 1'b0;
			full_step_out_n_o       <= 1'b1;
			media_port_select_out_o <= 1'b0;
			attachment_select_out_o <= 1'b0;
			mgmt_data_out_o         <= 1'b0;
			mgmt_clock_o            <= 1'b0;
		end else begin
			loopback_out_o          <= tx_ctrl_r[TX_CTRL_LOOP_BIT];
			full_step_out_n_o       <= ~cfg_r[CFG_FULL_STEP_BIT];
			media_port_select_out_o <= mii_sel;
			attachment_select_out_o <= cfg_r[CFG_ATTACH_BIT];
			mgmt_data_out_o         <= mgmt_r[MGMT_DOUT_BIT];
			mgmt_clock_o            <= mgmt_r[MGMT_MCLK_BIT];
		end
	end

	// Carrier and collision toward the deferral logic, from the active port only
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			carrier_o   <= 1'b0;
			collision_o <= 1'b0;
		end else begin
			carrier_o   <= mii_sel ? pins_s.fast_crs : pins_s.endec_crs;
			collision_o <= mii_sel ? pins_s.fast_col : pins_s.endec_col;
		end
	end

	// Transmit nibbles change just after a detected transmit clock rise, well before the next
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			fast_tx_envelope_o <= 1'b0;
			mii_txd_o          <= 4'h0;
			tx_ready_o         <= 1'b0;
			endec_tx_enable_o  <= 1'b0;
		end else begin
			tx_ready_o        <= 1'b0;
			endec_tx_enable_o <= ~mii_sel & tx_valid_i;
			if (!mii_sel) begin
				fast_tx_envelope_o <= 1'b0;
				mii_txd_o          <= 4'h0;
			end else if (tx_rise) begin
				fast_tx_envelope_o <= tx_valid_i;
				mii_txd_o          <= tx_valid_i ? tx_nibble_i : 4'h0;
				tx_ready_o         <= tx_valid_i;
			end
		end
	end

	assign frame_end = rx_rise && mii_sel && !pins_s.rx_dv && rx_st_r != RX_IDLE;
	assign frame_bad = err_r;

	// Receive framing: low nibble first, one byte per two nibbles
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			rx_st_r         <= RX_IDLE;
			lo_nib_r        <= 4'h0;
			err_r           <= 1'b0;
			first_r         <= 1'b0;
			rx_beat_o       <= '0;
			rx_beat_valid_o <= 1'b0;
			rx_discard_o    <= 1'b0;
		end else begin
			rx_beat_valid_o <= 1'b0;
			rx_discard_o    <= 1'b0;
			if (!mii_sel) begin
				rx_st_r <= RX_IDLE;
				err_r   <= 1'b0;
			end else if (rx_rise) begin
				if (!pins_s.rx_dv) begin
					rx_st_r <= RX_IDLE;
					err_r   <= 1'b0;
				end else begin
					if (pins_s.rx_er && !err_r) begin
						err_r        <= 1'b1;
						rx_discard_o <= 1'b1;
					end
					unique case (rx_st_r)
						RX_IDLE: begin
							lo_nib_r <= pins_s.rxd;
							first_r  <= 1'b1;
							rx_st_r  <= RX_HI;
						end
						RX_LO: begin
							lo_nib_r <= pins_s.rxd;
							rx_st_r  <= RX_HI;
						end
						RX_HI: begin
							// Once a code error is seen, the rest of the frame is dropped
							rx_beat_valid_o <= ~(err_r | pins_s.rx_er);
							rx_beat_o       <= '{first: first_r, data: {pins_s.rxd, lo_nib_r}};
							first_r         <= 1'b0;
							rx_st_r         <= RX_LO;
						end
						default: rx_st_r <= RX_IDLE;
					endcase
				end
			end
		end
	end

	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_tx_ctrl_wr;
		reg_wr_i && reg_addr_i == ADDR_TX_CTRL;
	endsequence

	sequence s_cfg_wr;
		reg_wr_i && reg_addr_i == ADDR_CFG;
	endsequence

	sequence s_tx_take;
		tx_rise && mii_sel && tx_valid_i;
	endsequence

	sequence s_err_seen;
		rx_rise && mii_sel && pins_s.rx_dv && pins_s.rx_er && !err_r;
	endsequence

	AST_LOOPBACK: assert property (s_tx_ctrl_wr |=> ##1 loopback_out_o == $past(reg_wdata_i[TX_CTRL_LOOP_BIT], 2))
		else $error("loopback pin does not follow loop bit");
	AST_FULL_STEP: assert property (s_cfg_wr |=> ##1 full_step_out_n_o != $past(reg_wdata_i[CFG_FULL_STEP_BIT], 2))
		else $error("full-step pin is not the inverse of its bit");
	AST_MEDIA_SEL: assert property (s_cfg_wr ##1 !reg_wr_i [*2] |-> media_port_select_out_o == $past(reg_wdata_i[CFG_MEDIA_SEL_BIT], 2))
		else $error("port select pin wrong");
	AST_ATTACH: assert property (s_cfg_wr |=> ##1 attachment_select_out_o == $past(reg_wdata_i[CFG_ATTACH_BIT], 2))
		else $error("attachment select pin wrong");
	AST_LINK: assert property (reg_rd_i && reg_addr_i == ADDR_PHY_ST |=> reg_rdata_o[PHY_ST_LINK_BIT] == !$past(pins_s.link_n))
		else $error("link status bit does not reflect input");
	AST_TX_ENV_LOW: assert property (!mii_sel |=> !fast_tx_envelope_o && mii_txd_o == 4'h0)
		else $error("fast envelope driven on encoder port");
	AST_CARRIER: assert property (1'b1 |=> carrier_o == $past(mii_sel ? pins_s.fast_crs : pins_s.endec_crs))
		else $error("carrier taken from wrong port");
	AST_COLLISION: assert property (mii_sel |=> collision_o == $past(pins_s.fast_col))
		else $error("collision taken from wrong port");
	AST_TXD: assert property (s_tx_take |=> tx_ready_o && fast_tx_envelope_o && mii_txd_o == $past(tx_nibble_i))
		else $error("transmit nibble not launched");
	AST_RX_IGNORED: assert property (!mii_sel |=> rx_st_r == RX_IDLE && !rx_beat_valid_o)
		else $error("receive pins used on encoder port");
	AST_DISCARD: assert property (s_err_seen |=> rx_discard_o && !rx_beat_valid_o)
		else $error("code error did not discard frame");
	AST_BAD_CRC: assert property (frame_end && err_r |=> rx_stat_r[RX_ST_BAD_CRC_BIT] && rx_stat_r[RX_ST_DONE_BIT])
		else $error("code error not reported as bad CRC");
	AST_ENDEC_ENDEC_TX_ENABLE: assert property (mii_sel |=> !endec_tx_enable_o)
		else $error("encoder transmit enable active on fast port");
	AST_MGMT: assert property (reg_wr_i && reg_addr_i == ADDR_MGMT |=> ##1 mgmt_clock_o == $past(reg_wdata_i[MGMT_MCLK_BIT], 2))
		else $error("management clock does not follow register");
endmodule

// File: tb/pps_phy_model.sv
`timescale 1ns/1ps
module pps_phy_model (
	input  wire logic       sys_clk_i,
	output logic            tx_clk_o,
	output logic            rx_clk_o,
	output logic            rx_dv_o,
	output logic            rx_er_o,
	output logic      [3:0] rxd_o,
	output logic            crs_o,
	output logic            col_o,
	output logic            endec_crs_o,
	output logic            endec_col_o,
	output logic            link_n_o,
	output logic            mgmt_din_o
);
	logic [2:0] rx_cnt_r = 3'h0;
	logic [2:0] tx_cnt_r = 3'h3;

	initial begin
		tx_clk_o = 1'b1;
		rx_clk_o = 1'b0;
		rx_dv_o = 1'b0;
		rx_er_o = 1'b0;
		rxd_o = 4'h5;
		{crs_o, col_o, endec_crs_o, endec_col_o, link_n_o, mgmt_din_o} = 6'h02;
	end

	// Both nibble clocks run free at 80 ns, out of phase with each other
	always @(posedge sys_clk_i) begin
		rx_cnt_r <= rx_cnt_r + 3'h1;
		tx_cnt_r <= tx_cnt_r + 3'h1;
		rx_clk_o <= rx_cnt_r[2];
		tx_clk_o <= tx_cnt_r[2];
	end

	// Launched one cycle after the receive clock falls so the nibble is settled three cycles before it rises
	task automatic put_nibble(input logic dv, input logic er, input logic [3:0] d);
		@(posedge sys_clk_i iff rx_cnt_r == 3'h1);
		rx_dv_o <= dv;
		rx_er_o <= er;
		rxd_o <= dv ? d : ~rxd_o;
	endtask

	task automatic set_pins(input logic [5:0] v);
		{crs_o, col_o, endec_crs_o, endec_col_o, link_n_o, mgmt_din_o} <= v;
	endtask
endmodule

// File: tb/pps_top_tb_top.sv
`timescale 1ns/1ps
module pps_top_tb_top;
	import pps_pkg::*;

	logic              sys_clk_i = 1'b0;
	logic              rst_i = 1'b1;
	logic [ADDR_W-1:0] reg_addr = '0;
	logic [DATA_W-1:0] reg_wdata = '0;
	logic              reg_wr = 1'b0, reg_rd = 1'b0, tx_valid = 1'b0, rd_pend = 1'b0;
	logic [3:0]        tx_nib = 4'h0;
	logic [DATA_W-1:0] rdata, v;
	pps_rx_beat_s      beat;
	logic              tx_ready, beat_vld, discard, carrier, collision, loopback, fstep_n, media_sel, attach_sel;
	logic              tx_env, mgmt_out, mgmt_clk, endec_en;
	logic [3:0]        txd, rxd;
	logic              tx_clk, rx_clk, rx_dv, rx_er, crs, col, ecrs, ecol, link_n, mgmt_din;
	logic [31:0]       lfsr = 32'hd5bc;
	logic [15:0]       exp_rd[$];
	logic [8:0]        exp_beat[$];
	logic [3:0]        exp_tx[$];
	int                mismatches = 0, cmp_count = 0, disc_cnt = 0, t;

	always #5 sys_clk_i = ~sys_clk_i;

	pps_phy_model i_phy (.sys_clk_i(sys_clk_i), .tx_clk_o(tx_clk), .rx_clk_o(rx_clk), .rx_dv_o(rx_dv),
		.rx_er_o(rx_er), .rxd_o(rxd), .crs_o(crs), .col_o(col), .endec_crs_o(ecrs), .endec_col_o(ecol),
		.link_n_o(link_n), .mgmt_din_o(mgmt_din));

	pps_top i_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
		.reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(rdata), .tx_valid_i(tx_valid), .tx_nibble_i(tx_nib),
		.tx_ready_o(tx_ready), .rx_beat_o(beat), .rx_beat_valid_o(beat_vld), .rx_discard_o(discard),
		.carrier_o(carrier), .collision_o(collision), .loopback_out_o(loopback), .full_step_out_n_o(fstep_n),
		.media_port_select_out_o(media_sel), .attachment_select_out_o(attach_sel), .link_status_in_n_i(link_n),
		.fast_tx_envelope_o(tx_env), .mii_txd_o(txd), .phy_tx_nibble_clock_i(tx_clk),
		.fast_carrier_sense_i(crs), .mii_rx_dv_i(rx_dv), .fast_collision_in_i(col),
		.phy_rx_nibble_clock_i(rx_clk), .mii_rxd_i(rxd), .mii_rx_er_i(rx_er), .mgmt_data_in_i(mgmt_din),
		.mgmt_data_out_o(mgmt_out), .mgmt_clock_o(mgmt_clk), .endec_tx_enable_o(endec_en),
		.endec_carrier_i(ecrs), .endec_collision_i(ecol));

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic end_sim;
		$display("Counts: compares=%0d mismatches=%0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic rnd(output logic [15:0] r);
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		r = lfsr[15:0];
	endtask

	// Leading edge keeps every strobe low for a cycle, so no signal is driven twice per step
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge sys_clk_i);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk_i);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge sys_clk_i);
		reg_addr <= a;
		reg_rd <= 1'b1;
		exp_rd.push_back(e);
		@(posedge sys_clk_i);
		reg_rd <= 1'b0;
	endtask

	task automatic frame(input int nn, input int er_at, input logic on);
		logic [15:0] r;
		logic [3:0]  lo;
		for (int k = 0; k < nn; k++) begin
			rnd(r);
			if (!k[0])
				lo = r[3:0];
			else if (on && k < er_at && k < nn)
				exp_beat.push_back({k == 1, r[3:0], lo});
			i_phy.put_nibble(1'b1, k == er_at, r[3:0]);
		end
		i_phy.put_nibble(1'b0, 1'b0, 4'h0);
		repeat (12) @(posedge sys_clk_i);
	endtask

	always @(posedge sys_clk_i) begin
		if (rd_pend)
			chk(rdata, exp_rd.pop_front());
		rd_pend = reg_rd;
		if (discard)
			disc_cnt++;
		if (beat_vld)
			chk({7'h0, beat}, exp_beat.size() ? {7'h0, exp_beat.pop_front()} : 16'hdead);
		if (tx_ready) begin
			chk({11'h0, tx_env, txd}, exp_tx.size() ? {11'h1, exp_tx.pop_front()} : 16'hdead);
		end
	end

	initial begin
		repeat (16) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		@(posedge sys_clk_i);
		chk({loopback, fstep_n, media_sel, attach_sel, tx_env, endec_en}, 16'h0010);
		rd(ADDR_TX_CTRL, TX_CTRL_RST);
		rd(ADDR_RX_ST, RX_ST_RST);
		rd(4'hf, 16'h0000);
		$display("reset test done");
		for (int i = 0; i < 8; i++) begin
			rnd(v);
			v = (v & 16'h7aff) | {i[0], 4'h0, i[1], 1'b0, i[2], 8'h00};
			wr(ADDR_CFG, v);
			wr(ADDR_TX_CTRL, {v[15:2], i[1] ^ i[2], v[0]});
			repeat (3) @(posedge sys_clk_i);
			chk(loopback, i[1] ^ i[2]);
			// Logical not keeps the expected value one bit wide; a bitwise not would widen first and set the upper fifteen bits to ones
			chk(fstep_n, !v[10]);
			chk(media_sel, v[15]);
			chk(attach_sel, v[8]);
		end
		$display("config pin test done");
		for (int j = 0; j < 32; j++) begin
			wr(ADDR_CFG, {j[4], 15'h0});
			wr(ADDR_MGMT, {14'h0, j[3:2]});
			i_phy.set_pins({j[3:0], j[0], j[1]});
			repeat (6) @(posedge sys_clk_i);
			chk(carrier, j[4] ? j[3] : j[1]);
			chk(collision, j[4] ? j[2] : j[0]);
			chk({mgmt_clk, mgmt_out}, j[3:2]);
			rd(ADDR_PHY_ST, {1'b0, ~j[0], 14'h0});
			rd(ADDR_MGMT, {13'h0, j[1], j[3:2]});
		end
		wr(ADDR_PHY_ST, 16'hffff);
		rd(ADDR_PHY_ST, 16'h0000);
		$display("pin select test done");
		wr(ADDR_CFG, 16'h8000);
		for (int k = 0; k < 6; k++) begin
			rnd(v);
			tx_nib <= v[3:0];
			tx_valid <= 1'b1;
			exp_tx.push_back(v[3:0]);
			t = 0;
			do begin
				@(posedge sys_clk_i);
				t++;
			end while (tx_ready !== 1'b1 && t < 40);
			if (t >= 40) begin
				mismatches++;
				end_sim();
			end
		end
		chk(endec_en, 1'b0);
		tx_valid <= 1'b0;
		repeat (20) @(posedge sys_clk_i);
		chk({tx_env, txd}, 5'h00);
		wr(ADDR_CFG, 16'h0000);
		tx_valid <= 1'b1;
		repeat (30) @(posedge sys_clk_i);
		chk({tx_env, txd, endec_en}, 6'h01);
		tx_valid <= 1'b0;
		$display("transmit test done");
		wr(ADDR_CFG, 16'h8000);
		frame(5, 99, 1'b1);
		rd(ADDR_RX_ST, 16'h0001);
		wr(ADDR_RX_ST, 16'hffff);
		frame(8, 2, 1'b1);
		chk(16'(disc_cnt), 16'h0001);
		rd(ADDR_RX_ST, 16'h2001);
		wr(ADDR_RX_ST, 16'hffff);
		wr(ADDR_CFG, 16'h0000);
		frame(6, 3, 1'b0);
		chk(16'(disc_cnt), 16'h0001);
		rd(ADDR_RX_ST, 16'h0000);
		repeat (4) @(posedge sys_clk_i);
		// Any expected read, byte or nibble never produced leaves a note behind
		chk(16'(exp_rd.size() + exp_beat.size() + exp_tx.size()), 16'h0000);
		$display("receive test done");
		end_sim();
	end
endmodule
